// ---- tb/cmc_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
module cmc_partner (
    output var logic        shift_clock,
    output var logic        shift_direction,
    output var logic        shift_request,
    input  wire logic       shift_done,
    output var logic        reconfig_clock,
    output var logic [6:0]  reconfig_address,
    output var logic [15:0] reconfig_write_data,
    output var logic        reconfig_write_enable,
    output var logic        reconfig_access_enable,
    input  wire logic [15:0] reconfig_data_out,
    input  wire logic       reconfig_ready
);
    // cleared by the bench while the manager runs without variable shifting
    logic shift_run = 1'b1;

    initial begin
        shift_clock = 1'b0;
        shift_direction = 1'b0;
        shift_request = 1'b0;
        reconfig_clock = 1'b0;
        reconfig_address = 7'h00;
        reconfig_write_data = 16'h0000;
        reconfig_write_enable = 1'b0;
        reconfig_access_enable = 1'b0;
        #130;
        forever #400 reconfig_clock = ~reconfig_clock;
    end

    always #400 shift_clock = shift_run & ~shift_clock;

    // request changes on the falling edge so it is steady around the rise that samples it
    task automatic shift(input logic dir, output logic ok);
        int n;
        @(negedge shift_clock);
        shift_direction <= dir;
        shift_request <= 1'b1;
        @(negedge shift_clock);
        shift_request <= 1'b0;
        shift_direction <= ~dir;
        ok = 1'b0;
        for (n = 0; n < 12 && !ok; n++) begin
            @(posedge shift_clock);
            ok = (shift_done === 1'b1);
        end
        @(posedge shift_clock);
    endtask

    task automatic rcfg(input logic we, input logic [6:0] a, input logic [15:0] d,
                        output logic [15:0] rd, output logic rdy);
        @(negedge reconfig_clock);
        reconfig_access_enable <= 1'b1;
        reconfig_write_enable <= we;
        reconfig_address <= a;
        reconfig_write_data <= d;
        @(negedge reconfig_clock);
        reconfig_access_enable <= 1'b0;
        reconfig_write_enable <= 1'b0;
        reconfig_address <= ~a;
        reconfig_write_data <= ~d;
        @(posedge reconfig_clock);
        rd = reconfig_data_out;
        rdy = reconfig_ready;
    endtask
endmodule // cmc_partner
`default_nettype wire

// ---- tb/cmc_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module cmc_properties
    import cmc_pkg::*;
#(
    parameter int LOCK_EDGES = 8
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mgr_reset,
    input wire logic        source_clock_in,
    input wire logic        feedback_clock_in,
    input wire logic        shift_clock,
    input wire logic        shift_direction,
    input wire logic        shift_request,
    input wire logic        shift_done,
    input wire logic        reconfig_clock,
    input wire logic [6:0]  reconfig_address,
    input wire logic [15:0] reconfig_write_data,
    input wire logic        reconfig_write_enable,
    input wire logic        reconfig_access_enable,
    input wire logic [15:0] reconfig_data_out,
    input wire logic        reconfig_ready,
    input wire logic        zero_degree_clock_out,
    input wire logic        locked_out
);
    logic [2:0]  src_q;
    logic [2:0]  src_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    // own view of source rises since the manager reset, to bound the lock time from below
    always_comb begin
        src_d = {src_q[1:0], source_clock_in};
        cnt_d = cnt_q;
        if (mgr_reset) begin
            cnt_d = 16'h0000;
        end else if (src_q[1] && !src_q[2] && cnt_q != 16'hffff) begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= 3'h0;
            cnt_q <= 16'h0000;
        end else begin
            src_q <= src_d;
            cnt_q <= cnt_d;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_after: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_err_decode: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
        else $error("pslverr decode wrong");
    chk_reset_clears: assert property (disable iff (!presetn) mgr_reset |-> !locked_out &&
        !shift_done && !zero_degree_clock_out && reconfig_data_out == 16'h0000)
        else $error("outputs not low in manager reset");
    chk_unlock_quiet: assert property ((!reconfig_ready)[*3] ##0 !locked_out
        |-> reconfig_data_out == 16'h0000)
        else $error("status shown while unlocked");
    chk_status_upper: assert property ((!reconfig_ready)[*3] |-> reconfig_data_out[15:4] == 12'h000)
        else $error("unassigned status bits set");
    chk_lock_count: assert property ($rose(locked_out) |-> cnt_q >= 16'(LOCK_EDGES))
        else $error("lock too early");
    chk_done_hold: assert property ($rose(shift_done) |=> shift_done[*6])
        else $error("shift done too short");
    chk_done_ends: assert property ($rose(shift_done) |-> ##[7:9] !shift_done)
        else $error("shift done too long");
    chk_done_locked: assert property ($rose(shift_done) |-> locked_out)
        else $error("shift done while unlocked");
endmodule // cmc_properties

bind cmc_top cmc_properties #(.LOCK_EDGES(LOCK_EDGES)) u_cmc_properties (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cmc_regs.svh"
module tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mgr_reset;
    logic        src;
    logic        s_clk;
    logic        s_dir;
    logic        s_req;
    logic        s_done;
    logic        r_clk;
    logic [6:0]  r_addr;
    logic [15:0] r_wdata;
    logic        r_we;
    logic        r_en;
    logic [15:0] r_dout;
    logic        r_rdy;
    logic        zero_degree_clock_out;
    logic        locked_out;
    int          fails;
    int          tests_run;

    cmc_top #(.LOCK_EDGES(8)) u_cmc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mgr_reset(mgr_reset), .source_clock_in(src),
        .feedback_clock_in(zero_degree_clock_out), .shift_clock(s_clk),
        .shift_direction(s_dir), .shift_request(s_req), .shift_done(s_done),
        .reconfig_clock(r_clk), .reconfig_address(r_addr), .reconfig_write_data(r_wdata),
        .reconfig_write_enable(r_we), .reconfig_access_enable(r_en),
        .reconfig_data_out(r_dout), .reconfig_ready(r_rdy),
        .zero_degree_clock_out(zero_degree_clock_out), .locked_out(locked_out));

    cmc_partner u_cmc_partner (.shift_clock(s_clk), .shift_direction(s_dir),
        .shift_request(s_req), .shift_done(s_done), .reconfig_clock(r_clk),
        .reconfig_address(r_addr), .reconfig_write_data(r_wdata),
        .reconfig_write_enable(r_we), .reconfig_access_enable(r_en),
        .reconfig_data_out(r_dout), .reconfig_ready(r_rdy));

    always #50 pclk = ~pclk;
    always #400 src = ~src;

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // this wait ends when pready goes high; the watchdog ends it if pready never comes
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        finish_test();
    end

    initial begin
        logic [31:0] r;
        logic [15:0] rd;
        logic        e;
        logic        ok;
        int          n;
        {pclk, src, psel, penable, pwrite, fails, tests_run} = '0;
        {paddr, pwdata} = '0;
        presetn = 1'b0;
        mgr_reset = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, r, e);
        chk(r, 32'(`CMC_CTRL_RESET));
        apb(1'b0, 12'h008, 32'h0, r, e);
        chk({r[31:1], e}, 32'h1);
        apb(1'b1, 12'h004, 32'hffffffff, r, e);
        chk({31'h0, e}, 32'h0);
        // feedback on, variable shifting
        apb(1'b1, 12'h000, 32'h5, r, e);
        repeat (20) @(posedge pclk);
        mgr_reset <= 1'b0;
        while (locked_out !== 1'b1) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk({27'h0, r[4:0]}, 32'h1);
        for (n = 0; n < 8; n++) begin
            u_cmc_partner.shift(1'b1, ok);
            chk({31'h0, ok}, 32'h1);
        end
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk({28'h0, r[11:8]}, 32'h7);
        chk({31'h0, r[1]}, 32'h1);
        chk({16'h0, r_dout}, 32'h1);
        u_cmc_partner.shift(1'b0, ok);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk({28'h0, r[11:8]}, 32'h6);
        u_cmc_partner.rcfg(1'b1, 7'h03, 16'ha5c3, rd, ok);
        chk({31'h0, ok}, 32'h1);
        u_cmc_partner.rcfg(1'b1, 7'h09, 16'h1234, rd, ok);
        u_cmc_partner.rcfg(1'b0, 7'h03, 16'h0, rd, ok);
        chk({16'h0, rd}, 32'ha5c3);
        u_cmc_partner.rcfg(1'b0, 7'h09, 16'h0, rd, ok);
        chk({16'h0, rd}, 32'h0);
        repeat (12) @(posedge pclk);
        chk({16'h0, r_dout}, 32'h1);
        mgr_reset <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({15'h0, locked_out, r_dout}, 32'h0);
        apb(1'b0, 12'h000, 32'h0, r, e);
        chk(r, 32'h5);
        // fixed mode: shift clock and request held low, fixed phase loaded at the second lock
        u_cmc_partner.shift_run = 1'b0;
        apb(1'b1, 12'h000, 32'h33, r, e);
        mgr_reset <= 1'b0;
        while (locked_out !== 1'b1) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk({19'h0, r[12:0]}, 32'h301);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire

// ---- verilog/cmc_pkg.sv ----
package cmc_pkg;
    typedef enum logic [1:0] {
        CMC_MODE_NONE,
        CMC_MODE_FIXED,
        CMC_MODE_VARIABLE,
        CMC_MODE_SPARE
    } cmc_mode_e;

    typedef enum logic [1:0] {
        CMC_LK_WAIT_SRC,
        CMC_LK_LOCKING,
        CMC_LK_LOCKED
    } cmc_lock_e;

    typedef enum logic [1:0] {
        CMC_SH_IDLE,
        CMC_SH_STEP,
        CMC_SH_ARM,
        CMC_SH_DONE
    } cmc_shift_e;

    typedef struct packed {
        logic [3:0] fixed_phase;
        cmc_mode_e  mode;
        logic       fb_en;
    } cmc_ctrl_s;

    // everything arriving from foreign clock domains
    typedef struct packed {
        logic        src;
        logic        fb;
        logic        sclk;
        logic        sdir;
        logic        sreq;
        logic        rclk;
        logic        rwe;
        logic        ren;
        logic [6:0]  raddr;
        logic [15:0] rdata;
    } cmc_pins_s;
endpackage

// ---- verilog/cmc_regs.svh ----
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

`define CMC_CTRL_OFS      12'h000
`define CMC_STATUS_OFS    12'h004

`define CMC_CTRL_FB_BIT   0
`define CMC_CTRL_MODE_LSB 1
`define CMC_CTRL_FIX_LSB  4
`define CMC_CTRL_RESET    7'h01

`define CMC_ST_LOCK_BIT   0
`define CMC_ST_STAT_LSB   1
`define CMC_ST_PHASE_LSB  8
`define CMC_ST_BUSY_BIT   12

`define CMC_PCLK_MHZ      10
`define CMC_STOP_NS       6400
`define CMC_STOP_CYCLES   ((`CMC_STOP_NS * `CMC_PCLK_MHZ) / 1000)
`define CMC_LOCK_EDGES    4096
`define CMC_TAP_MID       6'h08
`define CMC_RCFG_WORDS    8

`endif

// ---- verilog/cmc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cmc_regs.svh"

module cmc_top
    import cmc_pkg::*;
#(
    parameter int LOCK_EDGES = `CMC_LOCK_EDGES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        mgr_reset,
    input  wire logic        source_clock_in,
    input  wire logic        feedback_clock_in,
    input  wire logic        shift_clock,
    input  wire logic        shift_direction,
    input  wire logic        shift_request,
    output var  logic        shift_done,
    input  wire logic        reconfig_clock,
    input  wire logic [6:0]  reconfig_address,
    input  wire logic [15:0] reconfig_write_data,
    input  wire logic        reconfig_write_enable,
    input  wire logic        reconfig_access_enable,
    output var  logic [15:0] reconfig_data_out,
    output var  logic        reconfig_ready,
    output var  logic        zero_degree_clock_out,
    output var  logic        locked_out
);
    localparam logic [7:0]  STOP_CYC = 8'(`CMC_STOP_CYCLES);
    localparam logic [15:0] LOCK_LAST = 16'(LOCK_EDGES - 1);

    // core reset: the manager reset pin acts with no clock edge
    logic core_rst_n;
    assign core_rst_n = presetn & ~mgr_reset;

    // ---------------- apb register group ----------------
    cmc_ctrl_s   ctrl_q, ctrl_d;
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d;
    logic [31:0] status_word;

    always_comb begin
        ctrl_d    = ctrl_q;
        prdata_d  = prdata;
        pslverr_d = 1'b0;
        pready_d  = psel & penable & ~pready;
        if (pready_d) begin
            prdata_d = 32'h0000_0000;
            case (paddr)
                `CMC_CTRL_OFS: begin
                    if (pwrite) begin
                        ctrl_d.fb_en       = pwdata[`CMC_CTRL_FB_BIT];
                        ctrl_d.mode        = cmc_mode_e'(pwdata[`CMC_CTRL_MODE_LSB +: 2]);
                        ctrl_d.fixed_phase = pwdata[`CMC_CTRL_FIX_LSB +: 4];
                    end else begin
                        prdata_d[`CMC_CTRL_FB_BIT]        = ctrl_q.fb_en;
                        prdata_d[`CMC_CTRL_MODE_LSB +: 2] = ctrl_q.mode;
                        prdata_d[`CMC_CTRL_FIX_LSB +: 4]  = ctrl_q.fixed_phase;
                    end
                end
                `CMC_STATUS_OFS: begin
                    if (!pwrite) begin
                        prdata_d = status_word;
                    end
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= cmc_ctrl_s'(`CMC_CTRL_RESET);
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // ---------------- pin synchronisers ----------------
    cmc_pins_s pins, s1_q, s2_q, s3_q, f_q, f_d;
    assign pins = '{src: source_clock_in, fb: feedback_clock_in, sclk: shift_clock,
                    sdir: shift_direction, sreq: shift_request, rclk: reconfig_clock,
                    rwe: reconfig_write_enable, ren: reconfig_access_enable,
                    raddr: reconfig_address, rdata: reconfig_write_data};

    // a bit counts once the second and third stages agree
    always_comb begin
        f_d = f_q;
        for (int i = 0; i < $bits(cmc_pins_s); i++) begin
            if (s2_q[i] == s3_q[i]) begin
                f_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            f_q  <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q  <= f_d;
        end
    end

    logic src_rise, fb_rise, sclk_rise, rclk_rise;
    assign src_rise  = f_d.src & ~f_q.src;
    assign fb_rise   = f_d.fb & ~f_q.fb;
    assign sclk_rise = f_d.sclk & ~f_q.sclk;
    assign rclk_rise = f_d.rclk & ~f_q.rclk;

    // ---------------- clock manager core ----------------
    cmc_lock_e   lk_q, lk_d;
    cmc_shift_e  sh_q, sh_d;
    logic [31:0] line_q, line_d;
    logic [3:0]  base_q, base_d;
    logic [3:0]  phase_q, phase_d, target_q, target_d;
    logic [4:0]  tap_q, tap_d, tap_want;
    logic [15:0] lock_cnt_q, lock_cnt_d;
    logic [7:0]  fb_age_q, fb_age_d;
    logic [7:0]  idle_q [3], idle_d [3];
    logic        ovf_q, ovf_d, fx_stop_q, fx_stop_d;
    logic        clk_q, clk_d, lock_q, lock_d, done_q, done_d;
    logic [15:0] mem_q [`CMC_RCFG_WORDS], mem_d [`CMC_RCFG_WORDS];
    logic [15:0] rdo_q, rdo_d;
    logic        rdy_q, rdy_d;
    logic [3:0]  status;
    logic [4:0]  target_sum;

    // unlocked means all status reads as zero
    assign status = lock_q ? {idle_q[1] == STOP_CYC && ctrl_q.fb_en, fx_stop_q,
                              idle_q[0] == STOP_CYC, ovf_q} : 4'h0;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`CMC_ST_LOCK_BIT]       = lock_q;
        status_word[`CMC_ST_STAT_LSB +: 4]  = status;
        status_word[`CMC_ST_PHASE_LSB +: 4] = phase_q;
        status_word[`CMC_ST_BUSY_BIT]       = (sh_q != CMC_SH_IDLE);
    end

    always_comb begin
        lk_d       = lk_q;
        sh_d       = sh_q;
        base_d     = base_q;
        phase_d    = phase_q;
        target_d   = target_q;
        lock_cnt_d = lock_cnt_q;
        ovf_d      = ovf_q;
        lock_d     = lock_q;
        done_d     = done_q;
        mem_d      = mem_q;
        rdo_d      = rdo_q;
        rdy_d      = rdy_q;
        line_d     = {line_q[30:0], f_q.src};
        fb_age_d   = fb_rise ? 8'h00 : (fb_age_q == 8'hff ? fb_age_q : fb_age_q + 8'h01);
        // tap = deskew base + mid point + signed phase offset
        tap_want   = 5'(6'(base_q) + `CMC_TAP_MID + {{2{phase_q[3]}}, phase_q});
        target_sum = 5'({target_q[3], target_q}
                   + (f_d.sdir ? 5'h01 : 5'h1f));
        // move the tap only where old and new taps carry the same level
        tap_d = (line_q[tap_q] == line_q[tap_want]) ? tap_want : tap_q;
        clk_d = line_q[tap_q];
        fx_stop_d = fx_stop_q | (lock_q && idle_q[2] == STOP_CYC);
        idle_d[0] = src_rise ? 8'h00 : (idle_q[0] == STOP_CYC ? STOP_CYC : idle_q[0] + 8'h01);
        idle_d[1] = fb_rise ? 8'h00 : (idle_q[1] == STOP_CYC ? STOP_CYC : idle_q[1] + 8'h01);
        idle_d[2] = (clk_d & ~clk_q) ? 8'h00
                  : (idle_q[2] == STOP_CYC ? STOP_CYC : idle_q[2] + 8'h01);

        case (lk_q)
            CMC_LK_WAIT_SRC: begin
                if (src_rise) begin
                    lk_d       = CMC_LK_LOCKING;
                    lock_cnt_d = 16'h0000;
                end
            end
            CMC_LK_LOCKING: begin
                if (src_rise) begin
                    if (ctrl_q.fb_en && fb_age_q > 8'h01) begin
                        base_d     = base_q + 4'h1;
                        lock_cnt_d = 16'h0000;
                    end else if (lock_cnt_q == LOCK_LAST) begin
                        lk_d    = CMC_LK_LOCKED;
                        lock_d  = 1'b1;
                        phase_d = (ctrl_q.mode == CMC_MODE_FIXED) ? ctrl_q.fixed_phase : 4'h0;
                    end else begin
                        lock_cnt_d = lock_cnt_q + 16'h0001;
                    end
                end
            end
            CMC_LK_LOCKED: begin
            end
            default: begin
                lk_d = CMC_LK_WAIT_SRC;
            end
        endcase

        case (sh_q)
            CMC_SH_IDLE: begin
                if (sclk_rise && f_d.sreq && lock_q && ctrl_q.mode == CMC_MODE_VARIABLE) begin
                    if (target_sum[4] != target_sum[3]) begin
                        ovf_d = 1'b1;
                        sh_d  = CMC_SH_ARM;
                    end else begin
                        target_d = target_sum[3:0];
                        sh_d     = CMC_SH_STEP;
                    end
                end
            end
            CMC_SH_STEP: begin
                // one step per source cycle, done only when the tap has settled
                if (src_rise && phase_q != target_q) begin
                    phase_d = target_q;
                end else if (phase_q == target_q && tap_q == tap_want) begin
                    sh_d = CMC_SH_ARM;
                end
            end
            CMC_SH_ARM: begin
                if (sclk_rise) begin
                    done_d = 1'b1;
                    sh_d   = CMC_SH_DONE;
                end
            end
            CMC_SH_DONE: begin
                if (sclk_rise) begin
                    done_d = 1'b0;
                    sh_d   = CMC_SH_IDLE;
                end
            end
            default: begin
                sh_d = CMC_SH_IDLE;
            end
        endcase

        if (rclk_rise) begin
            rdy_d = 1'b0;
            if (f_d.ren) begin
                rdy_d = 1'b1;
                rdo_d = 16'h0000;
                if (f_d.raddr < 7'(`CMC_RCFG_WORDS)) begin
                    rdo_d = mem_q[f_d.raddr[2:0]];
                    if (f_d.rwe) begin
                        mem_d[f_d.raddr[2:0]] = f_d.rdata;
                    end
                end
            end
        end
        if (!f_q.ren && !rdy_d) begin
            rdo_d = {12'h000, status};
        end
    end

    always_ff @(posedge pclk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            lk_q       <= CMC_LK_WAIT_SRC;
            sh_q       <= CMC_SH_IDLE;
            line_q     <= 32'h0000_0000;
            base_q     <= 4'h0;
            phase_q    <= 4'h0;
            target_q   <= 4'h0;
            tap_q      <= 5'h00;
            lock_cnt_q <= 16'h0000;
            fb_age_q   <= 8'hff;
            ovf_q      <= 1'b0;
            fx_stop_q  <= 1'b0;
            clk_q      <= 1'b0;
            lock_q     <= 1'b0;
            done_q     <= 1'b0;
            rdo_q      <= 16'h0000;
            rdy_q      <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                idle_q[i] <= 8'h00;
            end
            for (int i = 0; i < `CMC_RCFG_WORDS; i++) begin
                mem_q[i] <= 16'h0000;
            end
        end else begin
            lk_q       <= lk_d;
            sh_q       <= sh_d;
            line_q     <= line_d;
            base_q     <= base_d;
            phase_q    <= phase_d;
            target_q   <= target_d;
            tap_q      <= tap_d;
            lock_cnt_q <= lock_cnt_d;
            fb_age_q   <= fb_age_d;
            ovf_q      <= ovf_d;
            fx_stop_q  <= fx_stop_d;
            clk_q      <= clk_d;
            lock_q     <= lock_d;
            done_q     <= done_d;
            rdo_q      <= rdo_d;
            rdy_q      <= rdy_d;
            idle_q     <= idle_d;
            mem_q      <= mem_d;
        end
    end

    assign zero_degree_clock_out = clk_q;
    assign locked_out            = lock_q;
    assign shift_done            = done_q;
    assign reconfig_data_out     = rdo_q;
    assign reconfig_ready        = rdy_q;
endmodule // cmc_top

`default_nettype wire
